// *** hw/scds_decimator_top.v ***
// Eight-channel modulator pacing, sinc3 decimation and input-select decoding
//
// Notes on behaviour
// - High-resolution mode paces modulator sampling at clock divided by four.
// - Low-power mode paces modulator sampling at clock divided by eight.
// - Each channel filters with the cube of (1-z^-N)/(1-z^-1).
// - Sinc stage takes modulator samples and emits parallel decimated words.
// - One global rate field sets the ratio for all channels.
// - Select 011 routes supply monitors; channels 3 and 4 see digital supply.
// - Select 010 with drive-measure bit set measures drive return input.
// - Gain field selects one of 1, 2, 3, 4, 6, 8 or 12.
// - Auxiliary differential pair selectable on any channel when pace unused.
// - Select 001 shorts inputs to mid-supply; 101 routes test signals.
// - Results are 24-bit two's complement, clipped at full-scale codes.
//
// The implementer's own choices: the register addresses and strobed register access.
`include "scds_defines.vh"
`default_nettype none
module scds_decimator_top (
    input  wire         clk,
    input  wire         resetn,
    input  wire [4:0]   regAddr,
    input  wire [23:0]  regWdata,
    input  wire         regWr,
    input  wire         regRd,
    output reg  [23:0]  regRdata,
    input  wire [7:0]   modBits,
    output reg          modSampleTick,
    output wire [191:0] chanWords,
    output wire         dataReady,
    output reg  [63:0]  chanRoute,
    output reg  [31:0]  chanGain,
    output wire [7:0]   supplyDigital
);
    // Route decode for one channel, one-hot
    function [7:0] decodeRoute;
        input [2:0] sel;
        input       driveMeas;
        input       paceUsed;
        begin
            decodeRoute = 8'h00;
            case (sel)
                `SCDS_SEL_NORMAL: begin
                    decodeRoute[`SCDS_RT_NORMAL] = 1'b1;
                end
                `SCDS_SEL_SHORT: begin
                    decodeRoute[`SCDS_RT_SHORT] = 1'b1;
                end
                `SCDS_SEL_DRIVE: begin
                    // Without the measure bit the code leaves normal inputs
                    if (driveMeas)
                        decodeRoute[`SCDS_RT_DRIVE] = 1'b1;
                    else
                        decodeRoute[`SCDS_RT_NORMAL] = 1'b1;
                end
                `SCDS_SEL_SUPPLY: begin
                    decodeRoute[`SCDS_RT_SUPPLY] = 1'b1;
                end
                `SCDS_SEL_TEMP: begin
                    decodeRoute[`SCDS_RT_TEMP] = 1'b1;
                end
                `SCDS_SEL_TEST: begin
                    decodeRoute[`SCDS_RT_TEST] = 1'b1;
                end
                `SCDS_SEL_AUX: begin
                    // Pace logic owns the pins while in use
                    if (paceUsed)
                        decodeRoute[`SCDS_RT_OFF] = 1'b1;
                    else
                        decodeRoute[`SCDS_RT_AUX] = 1'b1;
                end
                default: begin
                    decodeRoute[`SCDS_RT_OFF] = 1'b1;
                end
            endcase
        end
    endfunction

    // Gain code to amplifier gain value
    function [3:0] decodeGain;
        input [2:0] code;
        begin
            case (code)
                3'h0:    decodeGain = 4'h1;
                3'h1:    decodeGain = 4'h2;
                3'h2:    decodeGain = 4'h3;
                3'h3:    decodeGain = 4'h4;
                3'h4:    decodeGain = 4'h6;
                3'h5:    decodeGain = 4'h8;
                3'h6:    decodeGain = 4'hc;
                default: decodeGain = 4'h1;
            endcase
        end
    endfunction

    reg         lowPower_q;
    reg  [2:0]  rate_q;
    reg         driveMeas_q;
    reg         paceUsed_q;
    reg  [6:0]  chanSet_q [0:7];
    reg  [2:0]  divCnt_q;
    reg  [10:0] decCnt_q;
    reg  [7:0]  wordCount_q;
    wire [2:0]  divLast;
    wire        divHit;
    wire [2:0]  rateEff;
    wire [10:0] ratioM1;
    wire        decLast;
    wire        dumpEn;
    wire        rateWrite;
    wire [7:0]  validVec;
    wire [2:0]  chIdx;
    integer     i;
    integer     k;

    assign chIdx     = regAddr[2:0];
    assign rateWrite = regWr && (regAddr == `SCDS_ADDR_CFG2);

    // Modulator pacing: terminal count picks divide by four or eight
    assign divLast = lowPower_q ? `SCDS_DIV_LOWPWR : `SCDS_DIV_HIRES;
    assign divHit  = (divCnt_q == divLast);

    // Reserved rate codes fall back to the slowest ratio
    assign rateEff = (rate_q > `SCDS_RATE_MAX) ? `SCDS_RATE_MAX : rate_q;
    assign ratioM1 = (`SCDS_DEC_BASE << rateEff) - 11'h001;
    assign decLast = (decCnt_q == ratioM1);
    assign dumpEn  = modSampleTick & decLast;

    assign dataReady     = validVec[0];
    assign supplyDigital = `SCDS_SUPPLY_DIG_MASK;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q      <= 3'h0;
            modSampleTick <= 1'b0;
        end else begin
            modSampleTick <= divHit;
            if (divHit)
                divCnt_q <= 3'h0;
            else
                divCnt_q <= divCnt_q + 3'h1;
        end
    end

    // Shared decimation phase keeps every channel on the same output instant
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            decCnt_q    <= 11'h000;
            wordCount_q <= 8'h00;
        end else begin
            if (rateWrite)
                decCnt_q <= 11'h000;
            else if (modSampleTick)
                decCnt_q <= decLast ? 11'h000 : decCnt_q + 11'h001;
            if (dumpEn)
                wordCount_q <= wordCount_q + 8'h01;
        end
    end

    // Register writes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowPower_q  <= `SCDS_RST_MODE;
            rate_q      <= `SCDS_RST_RATE;
            driveMeas_q <= 1'b0;
            paceUsed_q  <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                chanSet_q[i] <= `SCDS_RST_CHSET;
        end else if (regWr) begin
            case (regAddr)
                `SCDS_ADDR_MODE: begin
                    lowPower_q <= regWdata[`SCDS_MODE_LOWPWR];
                end
                `SCDS_ADDR_CFG2: begin
                    rate_q <= regWdata[`SCDS_RATE_MSB:`SCDS_RATE_LSB];
                end
                `SCDS_ADDR_CFG3: begin
                    driveMeas_q <= regWdata[`SCDS_CFG3_DRVMEAS];
                    paceUsed_q  <= regWdata[`SCDS_CFG3_PACEUSED];
                end
                default: begin
                    if (regAddr[4:3] == 2'b01)
                        chanSet_q[chIdx] <= regWdata[6:0];
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 24'h000000;
        end else if (regRd) begin
            case (regAddr)
                `SCDS_ADDR_MODE: begin
                    regRdata <= {23'h000000, lowPower_q};
                end
                `SCDS_ADDR_CFG2: begin
                    regRdata <= {21'h000000, rate_q};
                end
                `SCDS_ADDR_CFG3: begin
                    regRdata <= {22'h000000, paceUsed_q, driveMeas_q};
                end
                `SCDS_ADDR_STATUS: begin
                    regRdata <= {5'h00, wordCount_q, decCnt_q};
                end
                default: begin
                    if (regAddr[4:3] == 2'b01)
                        regRdata <= {17'h00000, chanSet_q[chIdx][6:4], 1'b0,
                                     chanSet_q[chIdx][2:0]};
                    else if (regAddr[4:3] == 2'b10)
                        regRdata <= chanWords[chIdx*24 +: 24];
                    else
                        regRdata <= 24'h000000;
                end
            endcase
        end else begin
            regRdata <= 24'h000000;
        end
    end

    // Switch and gain controls registered so the analog side sees no glitches
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chanRoute <= {8{8'h01}};
            chanGain  <= {8{4'h1}};
        end else begin
            for (k = 0; k < 8; k = k + 1) begin
                chanRoute[k*8 +: 8] <= decodeRoute(chanSet_q[k][2:0],
                                                   driveMeas_q, paceUsed_q);
                chanGain[k*4 +: 4]  <= decodeGain(chanSet_q[k][6:4]);
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1) begin : gChan
            scds_sinc3_channel uFilter (
                .clk      (clk),
                .resetn   (resetn),
                .sampleEn (modSampleTick),
                .dataBit  (modBits[ch]),
                .dumpEn   (dumpEn),
                .rateSel  (rateEff),
                .outWord  (chanWords[ch*24 +: 24]),
                .outValid (validVec[ch])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// *** hw/scds_defines.vh ***
// Register offsets, field positions, reset values and decoder constants
`ifndef SCDS_DEFINES_VH
`define SCDS_DEFINES_VH

// Register port addresses (5-bit index)
`define SCDS_ADDR_MODE      5'h00
`define SCDS_ADDR_CFG2      5'h01
`define SCDS_ADDR_CFG3      5'h02
`define SCDS_ADDR_STATUS    5'h03
`define SCDS_ADDR_CHSET0    5'h08
`define SCDS_ADDR_RESULT0   5'h10

// Mode register: bit 0 selects low-power modulator rate
`define SCDS_MODE_LOWPWR    0
// Second configuration: rate select field
`define SCDS_RATE_LSB       0
`define SCDS_RATE_MSB       2
// Third configuration: drive-input measure bit, pace detection in use
`define SCDS_CFG3_DRVMEAS   0
`define SCDS_CFG3_PACEUSED  1
// Channel settings: input select [2:0], gain code [6:4]
`define SCDS_CH_MUX_LSB     0
`define SCDS_CH_MUX_MSB     2
`define SCDS_CH_GAIN_LSB    4
`define SCDS_CH_GAIN_MSB    6

// Reset values
`define SCDS_RST_MODE       1'h0
`define SCDS_RST_RATE       3'h6
`define SCDS_RST_CFG3       2'h0
`define SCDS_RST_CHSET      7'h00

// Modulator clock divide counts (terminal values)
`define SCDS_DIV_HIRES      3'h3
`define SCDS_DIV_LOWPWR     3'h7

// Decimation ratio = base shifted left by the rate code
`define SCDS_DEC_BASE       11'h010
`define SCDS_RATE_MAX       3'h6
// Pre-scale shift that maps the cubed full scale (2^12 at base) onto 2^23
`define SCDS_PRESHIFT       11

// Input select codes
`define SCDS_SEL_NORMAL     3'h0
`define SCDS_SEL_SHORT      3'h1
`define SCDS_SEL_DRIVE      3'h2
`define SCDS_SEL_SUPPLY     3'h3
`define SCDS_SEL_TEMP       3'h4
`define SCDS_SEL_TEST       3'h5
`define SCDS_SEL_AUX        3'h6

// One-hot route positions on the switch outputs
`define SCDS_RT_NORMAL      0
`define SCDS_RT_SHORT       1
`define SCDS_RT_DRIVE       2
`define SCDS_RT_SUPPLY      3
`define SCDS_RT_TEMP        4
`define SCDS_RT_TEST        5
`define SCDS_RT_AUX         6
`define SCDS_RT_OFF         7

// Channels 3 and 4 monitor the digital supply quarter
`define SCDS_SUPPLY_DIG_MASK 8'h0c

// Full-scale clip codes
`define SCDS_CLIP_POS       24'h7fffff
`define SCDS_CLIP_NEG       24'h800000

`endif

// *** hw/scds_sinc3_channel.v ***
// One channel of third-order sinc decimation with output scaling and clipping
`include "scds_defines.vh"
`default_nettype none
module scds_sinc3_channel (
    input  wire        clk,
    input  wire        resetn,
    input  wire        sampleEn,
    input  wire        dataBit,
    input  wire        dumpEn,
    input  wire [2:0]  rateSel,
    output reg  [23:0] outWord,
    output reg         outValid
);
    reg  signed [34:0] int1_q;
    reg  signed [34:0] int2_q;
    reg  signed [34:0] int3_q;
    reg  signed [34:0] dly1_q;
    reg  signed [34:0] dly2_q;
    reg  signed [34:0] dly3_q;
    wire signed [34:0] sampleVal;
    wire signed [34:0] comb1;
    wire signed [34:0] comb2;
    wire signed [34:0] comb3;
    wire        [4:0]  shiftAmt;
    wire signed [45:0] wide;
    wire               inRange;
    wire        [23:0] clipped;

    // Bitstream maps to +1/-1 so zero input gives a zero code
    assign sampleVal = dataBit ? 35'h000000001 : 35'h7ffffffff;

    // Comb differences taken at the output rate; wraparound is harmless
    assign comb1 = int3_q - dly1_q;
    assign comb2 = comb1 - dly2_q;
    assign comb3 = comb2 - dly3_q;

    // Gain is N^3 = 2^(12+3*rate): bring every rate to a 2^23 full scale
    assign shiftAmt = {1'b0, rateSel, 1'b0} + {2'b00, rateSel};
    assign wide     = $signed({comb3, 11'h000}) >>> shiftAmt;
    assign inRange  = (&wide[45:23]) | ~(|wide[45:23]);
    assign clipped  = inRange ? wide[23:0] :
                      (wide[45] ? `SCDS_CLIP_NEG : `SCDS_CLIP_POS);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int1_q   <= 35'h000000000;
            int2_q   <= 35'h000000000;
            int3_q   <= 35'h000000000;
            dly1_q   <= 35'h000000000;
            dly2_q   <= 35'h000000000;
            dly3_q   <= 35'h000000000;
            outWord  <= 24'h000000;
            outValid <= 1'b0;
        end else begin
            outValid <= 1'b0;
            if (sampleEn) begin
                int1_q <= int1_q + sampleVal;
                int2_q <= int2_q + int1_q;
                int3_q <= int3_q + int2_q;
            end
            if (dumpEn) begin
                dly1_q   <= int3_q;
                dly2_q   <= comb1;
                dly3_q   <= comb2;
                outWord  <= clipped;
                outValid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/scds_decimator_top_assertions.sv ***
// Port-level checks of pacing, decimation cadence and switch decoding
`default_nettype none
module scds_top_assertions (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [4:0]  regAddr,
    input wire logic [23:0] regWdata,
    input wire logic        regWr,
    input wire logic        modSampleTick,
    input wire logic        dataReady,
    input wire logic [63:0] chanRoute,
    input wire logic [31:0] chanGain,
    input wire logic [7:0]  supplyDigital
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        lowPower_q;
    logic        driveMeas_q;
    logic [2:0]  rate_q;
    logic [3:0]  settle_q;
    logic [3:0]  gap_q;
    logic        seen_q;
    logic [10:0] tickCnt_q;
    logic [10:0] ratio;
    assign ratio = 11'h010 << ((rate_q == 3'h7) ? 3'h6 : rate_q);
    // Spacing is judged only well after a mode change
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowPower_q <= 1'b0;
            driveMeas_q <= 1'b0;
            rate_q <= 3'h6;
            settle_q <= 4'h0;
            gap_q <= 4'h0;
            seen_q <= 1'b0;
            tickCnt_q <= 11'h000;
        end else begin
            if (regWr && regAddr == 5'h00) lowPower_q <= regWdata[0];
            if (regWr && regAddr == 5'h02) driveMeas_q <= regWdata[0];
            if (regWr && regAddr == 5'h01) rate_q <= regWdata[2:0];
            settle_q <= (regWr && regAddr == 5'h00) ? 4'h0 : settle_q + {3'h0, settle_q != 4'hf};
            gap_q <= modSampleTick ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
            seen_q <= (regWr && regAddr == 5'h01) ? 1'b0 : (seen_q | dataReady);
            tickCnt_q <= dataReady ? 11'h000 : tickCnt_q + {10'h000, modSampleTick};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_hires;
        modSampleTick && !lowPower_q && settle_q == 4'hf |-> gap_q == 4'h3;
    endproperty
    a_hires: assert property (p_hires) else $error("tick gap not four");
    property p_lowpwr;
        modSampleTick && lowPower_q && settle_q == 4'hf |-> gap_q == 4'h7;
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("tick gap not eight");
    property p_period;
        dataReady && seen_q |-> tickCnt_q == ratio;
    endproperty
    a_period: assert property (p_period) else $error("word period wrong");
    property p_after_tick;
        dataReady |-> $past(modSampleTick);
    endproperty
    a_after_tick: assert property (p_after_tick) else $error("ready not after tick");
    property p_pulse;
        dataReady |=> !dataReady [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_supply;
        regWr && regAddr == 5'h0a && regWdata[2:0] == 3'h3 |-> ##2 chanRoute[23:16] == 8'h08;
    endproperty
    a_supply: assert property (p_supply) else $error("supply route wrong");
    property p_drive;
        regWr && regAddr == 5'h09 && regWdata[2:0] == 3'h2
            |-> ##2 chanRoute[15:8] == (driveMeas_q ? 8'h04 : 8'h01);
    endproperty
    a_drive: assert property (p_drive) else $error("drive route wrong");
    property p_gain;
        regWr && regAddr == 5'h08 && regWdata[6:4] == 3'h6 |-> ##2 chanGain[3:0] == 4'hc;
    endproperty
    a_gain: assert property (p_gain) else $error("gain twelve wrong");
    property p_digital;
        supplyDigital == 8'h0c;
    endproperty
    a_digital: assert property (p_digital) else $error("supply kind wrong");
endmodule
bind scds_decimator_top scds_top_assertions i_scds_top_assertions (
    .clk, .resetn, .regAddr, .regWdata, .regWr, .modSampleTick, .dataReady,
    .chanRoute, .chanGain, .supplyDigital
);
`default_nettype wire

// *** tb/scds_decimator_top_tb.sv ***
// Register and stream bench for the eight-channel decimator
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module scds_decimator_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk;
    logic         resetn;
    logic [4:0]   regAddr;
    logic [23:0]  regWdata;
    logic         regWr;
    logic         regRd;
    logic [23:0]  regRdata;
    logic [7:0]   modBits;
    logic         modSampleTick;
    logic [191:0] chanWords;
    logic         dataReady;
    logic [63:0]  chanRoute;
    logic [31:0]  chanGain;
    logic [7:0]   supplyDigital;
    logic [7:0]   level;
    logic [63:0]  expRoute;
    logic [31:0]  expGain;
    int           bad_count;
    int           total_checks;
    int           n;
    scds_decimator_top i_scds_decimator_top (.clk, .resetn, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .modBits, .modSampleTick, .chanWords, .dataReady, .chanRoute,
        .chanGain, .supplyDigital);
    scds_mod_source i_scds_mod_source (.clk, .resetn, .tick(modSampleTick), .level,
        .bits(modBits));
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [23:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdata, e)
    endtask
    // Edges until the next strobe; a hang ends the run
    task automatic pulse(input bit r, output int k);
        for (k = 1; k < 9000; k++) begin
            @(posedge clk);
            #1;
            if (r ? dataReady : modSampleTick) return;
        end
        bad_count++;
        $display("[ERR] %0t got %h exp %h", $time, k, 9000);
        print_verdict();
    endtask
    function automatic logic [7:0] rt(input logic [2:0] c, input logic drv, input logic pace);
        case (c)
            3'h2: rt = drv ? 8'h04 : 8'h01;
            3'h6: rt = pace ? 8'h80 : 8'h40;
            default: rt = 8'h01 << c;
        endcase
    endfunction
    function automatic logic [3:0] gn(input logic [2:0] c);
        gn = (c == 3'h4) ? 4'h6 : (c == 3'h5) ? 4'h8 : (c == 3'h6) ? 4'hc :
             (c == 3'h7) ? 4'h1 : {1'b0, c} + 4'h1;
    endfunction
    task automatic check_map(input logic drv, input logic pace);
        for (int c = 0; c < 8; c++) begin
            expRoute[c*8+:8] = rt(3'(c + 1), drv, pace);
            expGain[c*4+:4] = gn(3'(c + 6));
        end
        `CHK(chanRoute, expRoute)
        `CHK(chanGain, expGain)
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        static int rl[4] = '{0, 1, 6, 7};
        resetn = 1'b0;
        regAddr = 5'h00;
        regWdata = 24'h000000;
        regWr = 1'b0;
        regRd = 1'b0;
        level = 8'h5a;
        bad_count = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        `CHK(chanRoute, {8{8'h01}})
        `CHK(chanGain, {8{4'h1}})
        `CHK(supplyDigital, 8'h0c)
        rd(5'h03, 24'h000000);
        rd(5'h01, 24'h000006);
        rd(5'h00, 24'h000000);
        rd(5'h1f, 24'h000000);
        pulse(0, n);
        pulse(0, n);
        `CHK(n, 4)
        wr(5'h00, 24'h000001);
        repeat (3) pulse(0, n);
        `CHK(n, 8)
        wr(5'h00, 24'h000000);
        wr(5'h02, 24'h000001);
        // Supply channel keeps unity gain to stay out of saturation
        for (int c = 0; c < 8; c++) wr(5'h08 + 5'(c), {17'h0, 3'(c + 6), 1'b0, 3'(c + 1)});
        for (int c = 0; c < 8; c++) rd(5'h08 + 5'(c), {17'h0, 3'(c + 6), 1'b0, 3'(c + 1)});
        check_map(1'b1, 1'b0);
        wr(5'h02, 24'h000002);
        rd(5'h02, 24'h000002);
        check_map(1'b0, 1'b1);
        // Reserved rate 7 must run at the slowest ratio
        for (int r = 0; r < 4; r++) begin
            level = r[0] ? 8'ha5 : 8'h5a;
            wr(5'h01, 24'(rl[r]));
            repeat (5) pulse(1, n);
            `CHK(n, 64 << ((rl[r] == 7) ? 6 : rl[r]))
            for (int c = 0; c < 8; c++) begin
                `CHK(chanWords[c*24+:24], level[c] ? 24'h7fffff : 24'h800000)
                rd(5'h10 + 5'(c), level[c] ? 24'h7fffff : 24'h800000);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// *** tb/scds_mod_source.sv ***
// Modulator bitstream source standing in for the eight channel modulators
`default_nettype none
module scds_mod_source (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic [7:0] level,
    output var  logic [7:0] bits
);
    timeunit 1ns;
    timeprecision 1ns;
    // New bits only after a sample strobe, as a real modulator would
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bits <= 8'h00;
        end else if (tick) begin
            bits <= level;
        end
    end
endmodule
`default_nettype wire
